// *** core/flash_self_program_ctrl.sv ***
// flash self-programming controller with an AHB-Lite register slave
//
// Summary of operation
// - reset vector is 0x0000 with fuse at 1, boot address at 0.
// - software has no path to alter the boot fuse.
// - pointer low bits select word in page, high bits select page.
// - target page is latched at start; pointer may change freely.
// - lock-bit programming ignores the pointer entirely.
// - load reads address bytes, pointer bit zero selects the byte.
// - code X0000011 plus store in four cycles erases selected page.
// - erase in halting section halts core; otherwise halting code readable.
// - code 00000001 plus store loads data word into buffer location.
// - buffer clears after page write, on re-enable, and on reset.
// - each buffer location takes one write between clears.
// - EEPROM write during page loading discards loaded words.
// - code X0000101 plus store writes buffer into selected page.
// - write in halting section halts core; otherwise fetches continue.
// - interrupt enabled means request held while enable bit is clear.
// - erase or write blocks concurrent-read section, busy flag set.
// - re-enable write after completion clears the busy flag.
// - code X0001001 plus store programs lock bits whose data is zero.
// - lock-bit programming halts neither section.
// - EEPROM write blocks programming and lock-bit reads.
// - armed bits self-clear without store in four; load reads accepted in three only.
`timescale 1ns/1ns
`default_nettype none

module flash_self_program_ctrl
  import flash_self_prog_pkg::*;
#(
  parameter int          PAGE_WORDS      = 64,
  parameter int          WORD_BITS       = $clog2(PAGE_WORDS),
  parameter int          PAGE_BITS       = 15 - WORD_BITS,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3F00,
  parameter int          HALTING_SECTION_FIRST_PAGE = 448
)(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  output var  logic [31:0]          hrdata,
  input  wire logic                 bootResetFuse,
  input  wire logic                 eepromWriteActive,
  input  wire logic                 flashOpDone,
  input  wire logic [LOCK_BITS-1:0] lockBitsState,
  input  wire logic [WORD_BITS-1:0] bufReadIndex,
  output var  logic [15:0]          resetVector,
  output var  logic                 eraseStart,
  output var  logic                 writeStart,
  output var  logic                 lockStart,
  output var  logic [PAGE_BITS-1:0] targetPage,
  output var  logic [LOCK_BITS-1:0] lockBitsProgram,
  output var  logic [15:0]          loadByteAddr,
  output var  logic [15:0]          bufReadWord,
  output var  logic                 cpuHalt,
  output var  logic                 rwwReadBlock,
  output var  logic                 spmIrq
);

  localparam logic [PAGE_BITS-1:0] HALT_PAGE = PAGE_BITS'(HALTING_SECTION_FIRST_PAGE);

  typedef struct packed {
    logic                                  dpPending;
    logic                                  dpWrite;
    logic [OFS_BITS-1:0]                   dpAddr;
    logic                                  readyOut;
    logic [31:0]                           rdata;
    logic [CMD_BITS-1:0]                   ctrlCmd;
    logic                                  irqEn;
    logic                                  busy;
    logic [2:0]                            armCnt;
    logic [15:0]                           pointer;
    logic [7:0]                            dataLow;
    logic [7:0]                            dataHigh;
    op_type                                op;
    logic [PAGE_BITS-1:0]                  page;
    logic [LOCK_BITS-1:0]                  lockProg;
    logic                                  eraseStart;
    logic                                  writeStart;
    logic                                  lockStart;
    logic [PAGE_WORDS-1:0]                 bufValid;
    logic [PAGE_WORDS-1:0][15:0]           buffer;
    logic [15:0]                           bufWord;
    logic                                  vecCaught;
    logic [15:0]                           vector;
    logic                                  halt;
    logic                                  irq;
  } state_type;

  state_type s_q;
  state_type s_d;
  cmd_type   cmd;
  logic      armed;
  logic      storeOk;
  logic      loadRdOk;
  logic [WORD_BITS-1:0] wordIdx;

  // refill the page buffer with erased words and forget all loads
  function automatic state_type clearBuffer(input state_type s);
    state_type r;
    // every word reads erased until it is loaded again
    r          = s;
    r.bufValid = '0;
    r.buffer   = {PAGE_WORDS{ERASED_WORD}};
    return r;
  endfunction

  // control/status readback: command bits, busy flag, interrupt enable
  function automatic logic [31:0] ctrlReadback(input state_type s);
    logic [31:0] r;
    r               = '0;
    r[CMD_BITS-1:0] = s.ctrlCmd;
    r[BIT_BUSY]     = s.busy;
    r[BIT_IRQEN]    = s.irqEn;
    return r;
  endfunction

  // page field of the pointer; word bits and byte select dropped
  function automatic logic [PAGE_BITS-1:0] pageOf(input logic [15:0] p);
    // shared by erase and write so both decode the page alike
    return p[15:WORD_BITS+1];
  endfunction

  // pages at or above the halting section stop the core while an erase or write runs
  function automatic logic inHaltSection(input logic [PAGE_BITS-1:0] p);
    return p >= HALT_PAGE;
  endfunction

  // command decode and the timing windows after arming
  assign cmd      = decodeCmd(s_q.ctrlCmd);
  assign armed    = s_q.ctrlCmd[BIT_ENABLE] && (s_q.op == OP_IDLE);
  assign storeOk  = armed && (s_q.armCnt < STORE_WINDOW);
  assign loadRdOk = armed && (s_q.armCnt < LOADRD_WINDOW);
  assign wordIdx  = s_q.pointer[WORD_BITS:1];

  // next-state logic for bus slave, commands and flash operations
  always_comb
  begin
    s_d            = s_q;
    s_d.eraseStart = 1'b0;
    s_d.writeStart = 1'b0;
    s_d.lockStart  = 1'b0;

    // window counter saturates so a late store never wraps into range
    if (armed && (s_q.armCnt != STORE_WINDOW))
    begin
      s_d.armCnt = s_q.armCnt + 3'h1;
    end

    // pick reset vector
    // caught once after reset release, never under the async reset
    if (!s_q.vecCaught)
    begin
      s_d.vecCaught = 1'b1;
      s_d.vector    = bootResetFuse ? APP_RESET_ADDR : BOOT_RESET_ADDR;
    end

    // one wait state: action and read data happen in the data phase
    if (s_q.dpPending)
    begin
      s_d.dpPending = 1'b0;
      s_d.readyOut  = 1'b1;
      s_d.rdata     = '0;
      if (s_q.dpWrite)
      begin
        case (s_q.dpAddr)
          OFS_CTRL:
          begin
            s_d.irqEn = hwdata[BIT_IRQEN];
            if (!eepromWriteActive && (s_q.op == OP_IDLE))
            begin
              s_d.ctrlCmd = hwdata[CMD_BITS-1:0];
              s_d.armCnt  = '0;
              if (decodeCmd(hwdata[CMD_BITS-1:0]) == CMD_REEN)
              begin
                s_d.busy     = 1'b0;
                s_d          = clearBuffer(s_d);
                s_d.ctrlCmd  = '0;
              end
            end
          end
          OFS_PTR_LOW:   s_d.pointer[7:0]  = hwdata[7:0];
          OFS_PTR_HIGH:  s_d.pointer[15:8] = hwdata[7:0];
          OFS_DATA_LOW:  s_d.dataLow       = hwdata[7:0];
          OFS_DATA_HIGH: s_d.dataHigh      = hwdata[7:0];
          OFS_STORE:
          begin
            if (storeOk && !eepromWriteActive)
            begin
              case (cmd)
                CMD_LOAD:
                begin
                  if (!s_q.bufValid[wordIdx])
                  begin
                    s_d.bufValid[wordIdx] = 1'b1;
                    s_d.buffer[wordIdx]   = {s_q.dataHigh, s_q.dataLow};
                  end
                  s_d.ctrlCmd = '0;
                end
                CMD_ERASE:
                begin
                  s_d.op         = OP_ERASE;
                  s_d.page       = pageOf(s_q.pointer);
                  s_d.eraseStart = 1'b1;
                  s_d.busy       = 1'b1;
                end
                CMD_WRITE:
                begin
                  s_d.op         = OP_WRITE;
                  s_d.page       = pageOf(s_q.pointer);
                  s_d.writeStart = 1'b1;
                  s_d.busy       = 1'b1;
                end
                CMD_LOCK:
                begin
                  s_d.op        = OP_LOCK;
                  s_d.lockProg  = s_q.dataLow[LOCK_BITS-1:0];
                  s_d.lockStart = 1'b1;
                end
                default: s_d.ctrlCmd = '0;
              endcase
            end
          end
          default: ;
        endcase
      end
      else
      begin
        case (s_q.dpAddr)
          OFS_CTRL:
          begin
            s_d.rdata = ctrlReadback(s_q);
          end
          OFS_PTR_LOW:   s_d.rdata[7:0] = s_q.pointer[7:0];
          OFS_PTR_HIGH:  s_d.rdata[7:0] = s_q.pointer[15:8];
          OFS_DATA_LOW:  s_d.rdata[7:0] = s_q.dataLow;
          OFS_DATA_HIGH: s_d.rdata[7:0] = s_q.dataHigh;
          OFS_LOAD:
          begin
            if (loadRdOk && (cmd == CMD_LOCK) && !eepromWriteActive)
            begin
              s_d.rdata[LOCK_BITS-1:0] = lockBitsState;
              s_d.ctrlCmd              = '0;
            end
          end
          default: ;
        endcase
      end
    end
    else if (hsel && htrans[HTRANS_ACTIVE] && hready)
    begin
      s_d.dpPending = 1'b1;
      s_d.dpWrite   = hwrite;
      s_d.dpAddr    = haddr[OFS_BITS-1:0];
      s_d.readyOut  = 1'b0;
    end

    if (armed && (s_q.armCnt == STORE_WINDOW) && (s_d.op == OP_IDLE))
    begin
      s_d.ctrlCmd = '0;
    end

    // completion: enable drops, which raises the interrupt if enabled
    if ((s_q.op != OP_IDLE) && flashOpDone)
    begin
      if (s_q.op == OP_WRITE)
      begin
        s_d = clearBuffer(s_d);
      end
      s_d.op      = OP_IDLE;
      s_d.ctrlCmd = '0;
    end

    if (eepromWriteActive && (s_q.bufValid != '0) && (s_q.op == OP_IDLE))
    begin
      s_d = clearBuffer(s_d);
    end

    // halt on erase in halting section
    // halt on write in halting section
    s_d.halt = 1'b0;
    if ((s_d.op == OP_ERASE) || (s_d.op == OP_WRITE))
    begin
      s_d.halt = inHaltSection(s_d.page);
    end

    // registered so the request pin never glitches on a bus write
    // level request while enable clear
    s_d.irq = s_d.irqEn & ~s_d.ctrlCmd[BIT_ENABLE];

    // buffer read port toward the flash array for page writes
    s_d.bufWord = s_q.buffer[bufReadIndex];
  end

  // single state register; async reset loads constants only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q           <= '0;
      s_q.readyOut  <= 1'b1;
      s_q.op        <= OP_IDLE;
      s_q.buffer    <= {PAGE_WORDS{ERASED_WORD}};
      s_q.bufWord   <= ERASED_WORD;
      s_q.vector    <= APP_RESET_ADDR;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops, except hresp tied low
  assign hreadyout       = s_q.readyOut;
  assign hresp           = 1'b0;
  assign hrdata          = s_q.rdata;
  assign resetVector     = s_q.vector;
  assign eraseStart      = s_q.eraseStart;
  assign writeStart      = s_q.writeStart;
  assign lockStart       = s_q.lockStart;
  assign targetPage      = s_q.page;
  assign lockBitsProgram = s_q.lockProg;
  assign loadByteAddr    = s_q.pointer;
  assign bufReadWord     = s_q.bufWord;
  assign cpuHalt         = s_q.halt;
  assign rwwReadBlock    = s_q.busy;
  assign spmIrq          = s_q.irq;

endmodule

`default_nettype wire

// *** core/flash_self_prog_pkg.sv ***
// constants, codes and types shared by the flash self-programming controller
package flash_self_prog_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PTR_LOW   = 8'h04;
  localparam logic [7:0] OFS_PTR_HIGH  = 8'h08;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h0C;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h10;
  localparam logic [7:0] OFS_STORE     = 8'h14;
  localparam logic [7:0] OFS_LOAD      = 8'h18;
  localparam int         OFS_BITS      = 8;

  // control/status bit positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_ERASE    = 1;
  localparam int BIT_WRITE    = 2;
  localparam int BIT_LOCKSET  = 3;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_IRQEN    = 7;
  localparam int CMD_BITS     = 6;

  // command codes held in control bits 5..0
  localparam logic [5:0] CODE_LOAD  = 6'h01;
  localparam logic [5:0] CODE_ERASE = 6'h03;
  localparam logic [5:0] CODE_WRITE = 6'h05;
  localparam logic [5:0] CODE_LOCK  = 6'h09;
  localparam logic [5:0] CODE_REEN  = 6'h11;

  // cycle windows after arming
  localparam logic [2:0] STORE_WINDOW  = 3'h4;
  localparam logic [2:0] LOADRD_WINDOW = 3'h3;

  // addresses, widths, fill values
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam int          LOCK_BITS      = 6;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  localparam int          HTRANS_ACTIVE  = 1;

  typedef enum {CMD_NONE, CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK,
                CMD_REEN} cmd_type;

  typedef enum {OP_IDLE, OP_ERASE, OP_WRITE, OP_LOCK} op_type;

  // map the control bits onto a command
  function automatic cmd_type decodeCmd(input logic [5:0] bits);
    cmd_type c;
    c = CMD_NONE;
    case (bits)
      CODE_LOAD:  c = CMD_LOAD;
      CODE_ERASE: c = CMD_ERASE;
      CODE_WRITE: c = CMD_WRITE;
      CODE_LOCK:  c = CMD_LOCK;
      CODE_REEN:  c = CMD_REEN;
      default:    c = CMD_NONE;
    endcase
    return c;
  endfunction

endpackage

// *** verification/flash_self_prog_props.sv ***
// property checker for the flash self-programming controller
`timescale 1ns/1ns
`default_nettype none
module flash_self_prog_props
  import flash_self_prog_pkg::*;
#(
  parameter int          PAGE_BITS       = 9,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3F00,
  parameter int          HALTING_SECTION_FIRST_PAGE = 448
)(
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 bootResetFuse,
  input wire logic                 eepromWriteActive,
  input wire logic                 eraseStart,
  input wire logic                 writeStart,
  input wire logic                 lockStart,
  input wire logic [PAGE_BITS-1:0] targetPage,
  input wire logic [15:0]          resetVector,
  input wire logic                 cpuHalt,
  input wire logic                 rwwReadBlock,
  input wire logic                 spmIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_vec;
    $past(rst_n) |-> resetVector ==
      (bootResetFuse ? APP_RESET_ADDR : BOOT_RESET_ADDR);
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");
  property p_latch;
    (eraseStart || writeStart) |=> $stable(targetPage)[*3];
  endproperty
  a_latch: assert property (p_latch) else $error("page moved");
  property p_busy;
    (eraseStart || writeStart) |=> rwwReadBlock[*4];
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_halt;
    cpuHalt |-> rwwReadBlock && targetPage >= HALTING_SECTION_FIRST_PAGE;
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_halting_section;
    $rose(rwwReadBlock) ##1 (targetPage >= HALTING_SECTION_FIRST_PAGE) |-> cpuHalt;
  endproperty
  a_halting_section: assert property (p_halting_section) else $error("no halt");
  property p_lock;
    lockStart |=> (!cpuHalt && !rwwReadBlock)[*4];
  endproperty
  a_lock: assert property (p_lock) else $error("lock blocked");
  property p_irq;
    (eraseStart || writeStart || lockStart) |-> !spmIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("early irq");
  property p_eep;
    eepromWriteActive && $past(eepromWriteActive)
      |-> !(eraseStart || writeStart || lockStart);
  endproperty
  a_eep: assert property (p_eep) else $error("start in eeprom");
  property p_pulse;
    eraseStart |=> !eraseStart && !writeStart && !lockStart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
endmodule

bind flash_self_program_ctrl flash_self_prog_props #(
  .PAGE_BITS       (PAGE_BITS),
  .BOOT_RESET_ADDR (BOOT_RESET_ADDR),
  .HALTING_SECTION_FIRST_PAGE (HALTING_SECTION_FIRST_PAGE)
) chk (.ref_clk, .rst_n, .bootResetFuse, .eepromWriteActive,
  .eraseStart, .writeStart, .lockStart, .targetPage, .resetVector,
  .cpuHalt, .rwwReadBlock, .spmIrq);
`default_nettype wire

// *** verification/flash_array_model.sv ***
// flash array stand-in: times operations and keeps lock bits
`timescale 1ns/1ns
`default_nettype none
module flash_array_model
  import flash_self_prog_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 slow,
  input  wire logic                 eraseStart,
  input  wire logic                 writeStart,
  input  wire logic                 lockStart,
  input  wire logic [LOCK_BITS-1:0] lockBitsProgram,
  output logic                      flashOpDone = 1'b0,
  output logic [LOCK_BITS-1:0]      lockBitsState = '1
);
  int cnt = 0;

  // countdown per op; slow mode stretches it, lock bits nonvolatile
  always @(posedge ref_clk)
  begin
    flashOpDone <= 1'b0;
    if (eraseStart || writeStart || lockStart)
      cnt <= slow ? 30 : 6;
    else if (cnt == 1)
      flashOpDone <= 1'b1;
    if (cnt > 0 && !(eraseStart || writeStart || lockStart))
      cnt <= cnt - 1;
    if (lockStart)
      lockBitsState <= lockBitsState & lockBitsProgram;
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import flash_self_prog_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        bootResetFuse = 1'b0;
  logic        eepromWriteActive = 1'b0;
  logic        slow = 1'b0;
  logic [5:0]  bufReadIndex = '0;
  logic        hreadyout, hresp, flashOpDone, eraseStart, writeStart;
  logic        lockStart, cpuHalt, rwwReadBlock, spmIrq;
  logic [31:0] hrdata;
  logic [5:0]  lockBitsState, lockBitsProgram;
  logic [8:0]  targetPage;
  logic [15:0] resetVector, loadByteAddr, bufReadWord;
  logic [31:0] rdQ[$];
  logic [15:0] opQ[$];
  logic        rdPend = 1'b0;
  logic [7:0]  codes [3] = '{8'h03, 8'h05, 8'h09};
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 32'h9b64781c;

  flash_self_program_ctrl #(.BOOT_RESET_ADDR(16'h3F00)) uut (.ref_clk,
    .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bootResetFuse,
    .eepromWriteActive, .flashOpDone, .lockBitsState, .bufReadIndex,
    .resetVector, .eraseStart, .writeStart, .lockStart, .targetPage,
    .lockBitsProgram, .loadByteAddr, .bufReadWord, .cpuHalt,
    .rwwReadBlock, .spmIrq);
  flash_array_model far (.ref_clk, .slow, .eraseStart, .writeStart,
    .lockStart, .lockBitsProgram, .flashOpDone, .lockBitsState);

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic setPtr(input logic [15:0] p);
    xfer(1'b1, OFS_PTR_LOW, {24'h0, p[7:0]});
    xfer(1'b1, OFS_PTR_HIGH, {24'h0, p[15:8]});
  endtask

  // arm a code, then store after gap idle cycles
  task automatic cmd(input logic [7:0] c, input int gap);
    xfer(1'b1, OFS_CTRL, {24'h0, c});
    repeat (gap) @(posedge ref_clk);
    xfer(1'b1, OFS_STORE, 32'h0);
  endtask

  task automatic loadWord(input logic [15:0] p, input logic [15:0] d);
    setPtr(p);
    xfer(1'b1, OFS_DATA_LOW, {24'h0, d[7:0]});
    xfer(1'b1, OFS_DATA_HIGH, {24'h0, d[15:8]});
    cmd(8'h01, 0);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watcher pairs each read or start pulse with the oldest note
  always @(posedge ref_clk)
  begin
    if (rdPend && hreadyout)
      chk(hrdata, rdQ.pop_front());
    if (hreadyout)
      rdPend = hsel && htrans[1] && !hwrite;
    if (eraseStart || writeStart || lockStart)
      chk({eraseStart, writeStart, lockStart, 4'h0, lockStart ?
        {3'h0, lockBitsProgram} : targetPage}, opQ.pop_front());
  end

  initial
  begin
    logic [15:0] d;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(resetVector, 16'h3F00);
    rd(8'h40, 32'h0);
    xfer(1'b1, OFS_PTR_LOW, 32'h5A);
    rd(OFS_PTR_LOW, 32'h5A);
    d = $random(seed);
    loadWord(16'h028A, d);
    bufReadIndex <= 6'h05;
    loadWord(16'h028A, ~d);
    chk(bufReadWord, d);
    // eeprom write mid-load drops buffer and blocks erase
    eepromWriteActive <= 1'b1;
    cmd(8'h03, 0);
    eepromWriteActive <= 1'b0;
    @(posedge ref_clk);
    chk(bufReadWord, ERASED_WORD);
    // store two cycles past the window is refused
    foreach (codes[i]) cmd(codes[i], 3);
    setPtr(16'h02BF);
    chk(loadByteAddr, 16'h02BF);
    slow <= 1'b1;
    opQ.push_back({7'h40, 9'd5});
    cmd(8'h83, 1);
    setPtr(16'hFFFF);
    chk({cpuHalt, rwwReadBlock}, 2'b01);
    while (!spmIrq) @(posedge ref_clk);
    xfer(1'b1, OFS_CTRL, 32'h11);
    chk(rwwReadBlock, 1'b0);
    slow <= 1'b0;
    // erase the page that the write below targets
    setPtr(16'hE100);
    opQ.push_back({7'h40, 9'd450});
    cmd(8'h03, 1);
    while (!flashOpDone) @(posedge ref_clk);
    xfer(1'b1, OFS_CTRL, 32'h11);
    loadWord(16'hE104, $random(seed));
    setPtr(16'hE100);
    opQ.push_back({7'h20, 9'd450});
    cmd(8'h85, 0);
    repeat (2) @(posedge ref_clk);
    chk(cpuHalt, 1'b1);
    bufReadIndex <= 6'h02;
    while (!spmIrq) @(posedge ref_clk);
    @(posedge ref_clk);
    chk(bufReadWord, ERASED_WORD);
    xfer(1'b1, OFS_CTRL, 32'h11);
    d = $random(seed);
    setPtr(d);
    xfer(1'b1, OFS_DATA_LOW, {24'h0, d[7:0]});
    opQ.push_back({7'h10, 3'h0, d[5:0]});
    cmd(8'h09, 1);
    while (!flashOpDone) @(posedge ref_clk);
    loadWord(16'h0004, d);
    rst_n <= 1'b0;
    bootResetFuse <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({resetVector, bufReadWord}, {16'h0000, ERASED_WORD});
    test_done();
  end

  initial
  begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
